// File: hdl/ifs_slave.sv
/*
 * Two-wire serial memory target: pin sampling, start/stop detection,
 * address matching, 64K x 8 array and a write buffer in front of it.
 * Assumes the bus master makes the serial clock and a pull-up on the data wire.
 */
// Contract
// - storage is 65,536 locations of eight bits each
// - each received data byte goes to the array without write delay; here bytes wait in an eight-entry write buffer first
// - respond only when address select bits match the select pins
// - unconnected select pins read as zero through pull-downs
// - data wire only pulled low or released, open drain
// - output changes on falling clock, input sampled on rising clock
// - protect pin high blocks every write, low allows all
// - unconnected protect pin reads low, so writes allowed
// - fixed read-only identification value is held
// - works at 100 kHz, 400 kHz and up to 3.4 MHz
// - sleep entered whether or not a stop follows the sleep command
// - first byte: type 1010 in 7-4, select in 3-1, read flag in 0
// - two-byte address latched, advanced per byte, wraps FFFF to 0000
// - a stop abandons any operation and readies a new one
// - bytes msb first; reads continue while master acknowledges

module ifs_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   wire              push = i_valid && o_ready;
   wire              pop  = o_valid && i_ready;

   // honest flags straight from the occupancy count
   assign o_ready = (count != (PW+1)'(DEPTH));
   assign o_valid = (count != '0);
   assign o_data  = store[rd_ptr];

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            store[wr_ptr] <= i_data;
            wr_ptr        <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
            rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : ifs_fifo

module ifs_slave #(
   parameter int          ADDR_W      = ifs_pkg::ADDR_W,
   parameter int          DEPTH       = ifs_pkg::FIFO_DEPTH,
   parameter logic [23:0] ID_CODE     = 24'h00_5a5a,   // arbitrary value
   parameter logic [7:0]  SLEEP_PREFX = 8'hf0          // arbitrary value
) (
   input  wire logic                         i_clock,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_scl,
   input  wire logic                         i_sda,
   output logic                              o_sda_o,
   output logic                              o_sda_oe,
   input  wire logic [ifs_pkg::SEL_W-1:0]    i_device_select_pins,
   input  wire logic                         i_wp,
   output logic                              o_sleep,
   output logic [23:0]                       o_device_id
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEVADDR, ST_ACK, ST_WRBYTE, ST_TXBYTE, ST_MACK
   } ifs_state_e;

   localparam int DW = ifs_pkg::DATA_W;

   ifs_state_e       state;
   logic [2:0]       scl_sy;
   logic [2:0]       sda_sy;
   logic [2:0]       wp_sy;
   logic             scl_f;
   logic             sda_f;
   logic             wp_f;
   logic             scl_p;
   logic             sda_p;
   logic [DW-1:0]    shreg;
   logic [DW-1:0]    txsh;
   logic [3:0]       cnt;
   logic [1:0]       idx;
   logic             rd_dir;
   logic             sleep_arm;
   logic             sleep_ack;
   logic [ADDR_W-1:0] addr;
   logic [DW-1:0]    rd_q;
   logic [DW-1:0]    mem [2**ADDR_W];

   // three-stage pin sampling; a level counts once stages two and three agree
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
         wp_sy  <= 3'h0;
      end else begin
         scl_sy <= {scl_sy[1:0], i_scl};
         sda_sy <= {sda_sy[1:0], i_sda};
         wp_sy  <= {wp_sy[1:0], i_wp};
      end
   end

   // filtered levels; a floating protect pin arrives low from its pull-down
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         wp_f  <= 1'b0;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         if (scl_sy[1] == scl_sy[2]) scl_f <= scl_sy[2];
         if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
         if (wp_sy[1] == wp_sy[2])   wp_f  <= wp_sy[2];
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end

   // bus events; at 40 MHz a 3.4 MHz clock still gives several samples per phase
   wire scl_rise = scl_f && !scl_p;
   wire scl_fall = !scl_f && scl_p;
   wire start_ev = scl_f && scl_p && sda_p && !sda_f;
   wire stop_ev  = scl_f && scl_p && !sda_p && sda_f;

   // address byte decode; select pins rely on their pull-downs when open
   wire addr_hit   = (shreg[ifs_pkg::TYPE_HI:ifs_pkg::TYPE_LO] == ifs_pkg::DEV_TYPE) &&
                     (shreg[ifs_pkg::SEL_HI:ifs_pkg::SEL_LO] == i_device_select_pins);
   wire sleep_pfx  = (shreg == SLEEP_PREFX);
   wire byte_in    = (cnt == ifs_pkg::BITS_BYTE);
   wire data_byte  = (idx == ifs_pkg::IDX_DATA);
   wire [ADDR_W-1:0] addr_inc = addr + 1'b1;

   // write buffer; a full buffer refuses an unprotected byte with a no-acknowledge
   ifs_pkg::ifs_wr_s wr_in;
   ifs_pkg::ifs_wr_s wr_out;
   logic             wr_rdy;
   logic             wr_vld;
   logic             push;
   wire              drain_rdy = (state != ST_TXBYTE);  // reads hold off array writes
   assign wr_in = '{addr: addr, data: shreg};

   ifs_fifo #(
      .WIDTH ($bits(ifs_pkg::ifs_wr_s)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_valid   (push),
      .o_ready   (wr_rdy),
      .i_data    (wr_in),
      .o_valid   (wr_vld),
      .i_ready   (drain_rdy),
      .o_data    (wr_out)
   );

   // protected data is acknowledged but never enters the buffer
   assign push = scl_fall && (state == ST_WRBYTE) && byte_in && data_byte && !wp_f && wr_rdy;

   // array: one write port from the buffer, one registered read port
   always_ff @(posedge i_clock) begin
      if (wr_vld && drain_rdy)
         mem[wr_out.addr] <= wr_out.data;
      rd_q <= mem[addr];
   end

   // identification value held read-only
   always_ff @(posedge i_clock) begin
      if (i_sys_rst)
         o_device_id <= ID_CODE;
      else
         o_device_id <= ID_CODE;
   end

   // bus state machine; data wire is only ever pulled low or released
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state     <= ST_IDLE;
         o_sda_o   <= 1'b0;
         o_sda_oe  <= 1'b0;
         o_sleep   <= 1'b0;
         shreg     <= ifs_pkg::BYTE_RST;
         txsh      <= ifs_pkg::BYTE_RST;
         cnt       <= '0;
         idx       <= ifs_pkg::IDX_ADDR_HI;
         rd_dir    <= 1'b0;
         sleep_arm <= 1'b0;
         sleep_ack <= 1'b0;
         addr      <= ifs_pkg::ADDR_RST;
      end else if (stop_ev) begin
         state     <= ST_IDLE;
         o_sda_oe  <= 1'b0;
         sleep_arm <= 1'b0;
      end else if (start_ev) begin
         state     <= ST_DEVADDR;
         o_sda_oe  <= 1'b0;
         cnt       <= '0;
         sleep_ack <= 1'b0;
      end else if (scl_rise) begin
         unique case (state)
            ST_DEVADDR, ST_WRBYTE: begin
               shreg <= {shreg[DW-2:0], sda_f};
               cnt   <= cnt + 1'b1;
            end
            ST_MACK: begin
               if (sda_f)
                  state <= ST_IDLE;
            end
            ST_IDLE, ST_ACK, ST_TXBYTE: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (state)
            ST_DEVADDR: begin
               if (byte_in) begin
                  cnt <= '0;
                  if (sleep_pfx && !sleep_arm) begin
                     sleep_arm <= 1'b1;                  // await our own address
                     cnt       <= '1;                    // prefix's ninth clock wraps count to zero
                  end else if (addr_hit) begin
                     state     <= ST_ACK;
                     o_sda_oe  <= 1'b1;
                     rd_dir    <= shreg[ifs_pkg::DIR_BIT];
                     idx       <= ifs_pkg::IDX_ADDR_HI;
                     sleep_ack <= sleep_arm;
                     sleep_arm <= 1'b0;
                     if (sleep_arm)
                        o_sleep <= 1'b1;                 // sticky until reset
                  end else begin
                     state     <= ST_IDLE;
                     sleep_arm <= 1'b0;
                  end
               end
            end
            ST_WRBYTE: begin
               if (byte_in) begin
                  cnt <= '0;
                  if (idx == ifs_pkg::IDX_ADDR_HI) begin
                     addr[ADDR_W-1:DW] <= shreg[ADDR_W-DW-1:0];
                     idx   <= ifs_pkg::IDX_ADDR_LO;
                     state <= ST_ACK;
                     o_sda_oe <= 1'b1;
                  end else if (idx == ifs_pkg::IDX_ADDR_LO) begin
                     addr[DW-1:0] <= shreg;
                     idx   <= ifs_pkg::IDX_DATA;
                     state <= ST_ACK;
                     o_sda_oe <= 1'b1;
                  end else if (wr_rdy || wp_f) begin
                     addr     <= addr_inc;
                     state    <= ST_ACK;
                     o_sda_oe <= 1'b1;
                  end else begin
                     state    <= ST_IDLE;                // buffer full: byte refused
                  end
               end
            end
            ST_ACK: begin
               cnt <= '0;
               if (sleep_ack) begin
                  state    <= ST_IDLE;
                  o_sda_oe <= 1'b0;
               end else if (rd_dir) begin
                  state    <= ST_TXBYTE;
                  txsh     <= {rd_q[DW-2:0], 1'b0};
                  o_sda_oe <= !rd_q[DW-1];
                  addr     <= addr_inc;
                  cnt      <= 4'h1;
               end else begin
                  state    <= ST_WRBYTE;
                  o_sda_oe <= 1'b0;
               end
            end
            ST_TXBYTE: begin
               if (byte_in) begin
                  state    <= ST_MACK;
                  o_sda_oe <= 1'b0;
               end else begin
                  o_sda_oe <= !txsh[DW-1];
                  txsh     <= {txsh[DW-2:0], 1'b0};
                  cnt      <= cnt + 1'b1;
               end
            end
            ST_MACK: begin
               state    <= ST_TXBYTE;
               txsh     <= {rd_q[DW-2:0], 1'b0};
               o_sda_oe <= !rd_q[DW-1];
               addr     <= addr_inc;
               cnt      <= 4'h1;
            end
            ST_IDLE: begin
            end
         endcase
      end
   end

endmodule : ifs_slave

// File: common/ifs_pkg.sv
/*
 * Shared constants and types for the two-wire memory target front end.
 * Assumes a 40 MHz system clock that samples the serial bus pins.
 */
package ifs_pkg;

   // storage geometry and select pin count
   localparam int          ADDR_W      = 16;
   localparam int          DATA_W      = 8;
   localparam int          SEL_W       = 3;

   // first byte after a start: type code, select bits, direction
   localparam logic [3:0]  DEV_TYPE    = 4'ha;
   localparam int          TYPE_HI     = 7;
   localparam int          TYPE_LO     = 4;
   localparam int          SEL_HI      = 3;
   localparam int          SEL_LO      = 1;
   localparam int          DIR_BIT     = 0;

   // bit and byte counting
   localparam logic [3:0]  BITS_BYTE   = 4'h8;
   localparam logic [1:0]  IDX_ADDR_HI = 2'h0;
   localparam logic [1:0]  IDX_ADDR_LO = 2'h1;
   localparam logic [1:0]  IDX_DATA    = 2'h2;

   // buffering between the link and the array
   localparam int          FIFO_DEPTH  = 8;

   // clock and bus rates
   localparam real         SYS_CLK_MHZ = 40.0;
   localparam real         SCL_MAX_KHZ = 3400.0;
   localparam int          SCL_MIN_CYC = int'(SYS_CLK_MHZ * 1000.0 / SCL_MAX_KHZ);

   // reset values
   localparam logic [15:0] ADDR_RST    = 16'h0000;
   localparam logic [7:0]  BYTE_RST    = 8'h00;

   // one buffered write to the array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } ifs_wr_s;

endpackage : ifs_pkg

// File: tb/ifs_slave_checker.sv
/* pin-level checks for ifs_slave, bound to every instance.
   assumes one clock domain and a bus master that never stretches the clock */
module ifs_slave_checker #(
   parameter logic [23:0] ID_CODE = 24'h00_5a5a
) (
   input wire logic                      i_clock,
   input wire logic                      i_sys_rst,
   input wire logic                      i_scl,
   input wire logic                      i_sda,
   input wire logic                      o_sda_o,
   input wire logic                      o_sda_oe,
   input wire logic [ifs_pkg::SEL_W-1:0] i_device_select_pins,
   input wire logic                      i_wp,
   input wire logic                      o_sleep,
   input wire logic [23:0]               o_device_id
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       scl_q;
   logic [3:0] fall_age;  // clocks since the last clock-pin fall
   logic [3:0] high_age;  // clocks the clock pin has stayed high
   // saturating ages, so a long idle bus cannot wrap back to small values
   always_ff @(posedge i_clock) begin
      scl_q    <= i_scl;
      fall_age <= (i_sys_rst || (scl_q && !i_scl)) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
      high_age <= (i_sys_rst || !i_scl) ? 4'h0 : high_age + {3'h0, high_age != 4'hf};
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   a_drive_only_low: assert property (!o_sda_o) else $error("data wire driven high");
   a_id_constant: assert property (o_device_id == ID_CODE) else $error("id value moved");
   a_sleep_sticky: assert property (o_sleep |=> o_sleep) else $error("sleep flag dropped");
   a_oe_after_fall: assert property ($changed(o_sda_oe) |-> fall_age inside {[2:6]})
      else $error("data drive moved away from a clock fall");
   a_oe_high_stands: assert property ($rose(o_sda_oe) |=> o_sda_oe[*6]) else $error("drive too short");
   a_oe_low_stands: assert property ($fell(o_sda_oe) |=> !o_sda_oe[*6]) else $error("release too short");
   a_idle_released: assert property (high_age == 4'hf |-> !o_sda_oe) else $error("drive on idle bus");
   a_reset_quiet: assert property ($fell(i_sys_rst) |-> !o_sda_oe && !o_sleep) else $error("not quiet");
   c_ack: cover property ($rose(o_sda_oe));
   c_sleep: cover property ($rose(o_sleep));
   c_protect: cover property (i_wp && $fell(o_sda_oe));
endmodule : ifs_slave_checker

bind ifs_slave ifs_slave_checker #(.ID_CODE(ID_CODE)) chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
   .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
   .i_device_select_pins(i_device_select_pins), .i_wp(i_wp), .o_sleep(o_sleep), .o_device_id(o_device_id));

// File: tb/ifs_master_model.sv
/* two-wire bus master model: makes the serial clock, pulls data low.
   assumes the bench resolves the data wire with a pull-up */
module ifs_master_model (
   input  wire logic i_clock,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus: clock high and still, data released
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask : tick
   // 8 clocks per bit, 200 ns; data moves a clock after the fall
   task automatic bit_io(input logic b, output logic r);
      tick(1);
      o_sda_low <= !b;
      tick(4);
      o_scl <= 1'b1;
      tick(2);
      r = i_sda;
      tick(1);
      o_scl <= 1'b0;
   endtask : bit_io
   // data falls with clock high; also serves as repeated start
   task automatic start;
      tick(1);
      o_sda_low <= 1'b0;
      tick(4);
      o_scl <= 1'b1;
      tick(4);
      o_sda_low <= 1'b1;
      tick(4);
      o_scl <= 1'b0;
   endtask : start
   task automatic stop;
      tick(1);
      o_sda_low <= 1'b1;
      tick(4);
      o_scl <= 1'b1;
      tick(4);
      o_sda_low <= 1'b0;
      tick(4);
   endtask : stop
   // msb first, address format supplied by caller
   task automatic byte_w(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : byte_w
   // withholding the acknowledge ends a read
   task automatic byte_r(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask : byte_r
endmodule : ifs_master_model

// File: tb/tb_i2c_fram_slave_interface.sv
/* self-checking bench for ifs_slave driven by the master model.
   assumes the checker is bound from its own file */
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, (exp), (got)); end end
module tb_i2c_fram_slave_interface;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [23:0] ID  = 24'h00_1234;  // arbitrary value
   localparam logic [7:0]  SLP = 8'hf0;        // arbitrary value
   logic        i_clock = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        i_wp = 1'b0;
   logic [2:0]  sel = 3'h0;
   logic        scl, sda_low, oe, sda_o, sleep, a;
   logic [23:0] dev_id;
   logic [4:0]  acks;
   logic [15:0] rd;
   int          miscompares = 0;
   int          n_compared = 0;
   wire         sda = !(sda_low || oe);  // pull-up wins unless someone pulls low
   always #12.5 i_clock = ~i_clock;
   ifs_master_model m (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   ifs_slave #(.ID_CODE(ID), .SLEEP_PREFX(SLP)) uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_scl(scl),
      .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(oe), .i_device_select_pins(sel), .i_wp(i_wp),
      .o_sleep(sleep), .o_device_id(dev_id));
   function automatic logic [7:0] dev(input logic [2:0] s, input logic rw);
      return {ifs_pkg::DEV_TYPE, s, rw};
   endfunction : dev
   task automatic wr2(input logic [15:0] ad, input logic [7:0] d0, input logic [7:0] d1);
      m.start;
      m.byte_w(dev(sel, 1'b0), acks[4]);
      m.byte_w(ad[15:8], acks[3]);
      m.byte_w(ad[7:0], acks[2]);
      m.byte_w(d0, acks[1]);
      m.byte_w(d1, acks[0]);
      m.stop;
   endtask : wr2
   // random read of two bytes: address write, repeated start, ack then nack
   task automatic rd2(input logic [15:0] ad);
      m.start;
      m.byte_w(dev(sel, 1'b0), a);
      m.byte_w(ad[15:8], a);
      m.byte_w(ad[7:0], a);
      m.start;
      m.byte_w(dev(sel, 1'b1), a);
      m.byte_r(1'b1, rd[15:8]);
      m.byte_r(1'b0, rd[7:0]);
      m.stop;
   endtask : rd2
   // open straps, write across the top address, read straight back
   task automatic t_wrap;
      wr2(16'hffff, 8'h3c, 8'ha5);
      `CHK("write acks", 5'h1f, acks)
      rd2(16'hffff);
      `CHK("wrapped read", 16'h3ca5, rd)
   endtask : t_wrap
   // all eight select codes against straps set to 5 and a foreign type code
   task automatic t_select;
      sel <= 3'h5;
      for (int i = 0; i < 9; i++) begin
         m.start;
         m.byte_w(i < 8 ? dev(i[2:0], 1'b0) : 8'hba, a);
         m.stop;
         `CHK("select ack", (i == 5), a)
      end
   endtask : t_select
   // protected write is answered and advances, array kept; stop aborts
   task automatic t_protect;
      wr2(16'h0010, 8'h11, 8'h22);
      wr2(16'h0012, 8'h33, 8'h44);
      i_wp <= 1'b1;
      wr2(16'h0010, 8'h5a, 8'h66);
      `CHK("protected acks", 5'h1f, acks)
      m.start;
      m.byte_w(dev(sel, 1'b1), a);
      m.byte_r(1'b0, rd[7:0]);
      m.stop;
      `CHK("advanced address", 8'h33, rd[7:0])
      rd2(16'h0010);
      `CHK("protected data", 16'h1122, rd)
      i_wp <= 1'b0;
      wr2(16'h0010, 8'h5a, 8'h66);
      m.start;
      m.byte_w(dev(sel, 1'b0), a);
      m.byte_w(8'h00, a);
      m.stop;
      rd2(16'h0010);
      `CHK("after abort", 16'h5a66, rd)
   endtask : t_protect
   // sleep without a closing stop
   task automatic t_sleep;
      m.start;
      m.byte_w(SLP, a);
      m.byte_w(dev(sel, 1'b0), a);
      m.tick(8);
      `CHK("sleep ack", 1'b1, a)
      `CHK("sleep flag", 1'b1, sleep)
      `CHK("device id", ID, dev_id)
   endtask : t_sleep
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (4) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      repeat (6) @(posedge i_clock);
      t_wrap;
      t_select;
      t_protect;
      t_sleep;
      give_verdict;
   end
   // the run needs about 5k clocks
   initial begin
      repeat (40000) @(posedge i_clock);
      miscompares++;
      give_verdict;
   end
endmodule : tb_i2c_fram_slave_interface
